// ==== hdl/pio_top.sv ====
// parallel i/o port logic: latches, direction, open drain, thresholds, alternate paths
// What this block does
// R1 - sample every pin once per state time
// R2 - input pin: write latch, read pin
// R3 - input pin rmw uses pin, stores latch
// R4 - output pin: write drives, read latch
// R5 - output pin rmw uses latch value
// R6 - per-bit open-drain select where supported
// R7 - threshold select one bit per byte
// R8 - threshold never affects direction or mode
// R9 - alternate output needs output direction
// R10 - pin is latch and alternate, except pwm
// R11 - all directions reset to input
// R12 - output direction feeds latch to alternate input
// R13 - hardware owns direction for bus-type functions
// R14 - reset-time outputs get direction automatically
// R15 - port three line fourteen absent
// R16 - port five input only, sixteen lines
// R17 - ports zero and one have byte halves
// R18 - software sets direction before alternate use
// R19 - control bits reset zero, effective next cycle
`timescale 1ns/1ps
module pio_top #(
   parameter int                STATE_CLKS   = pio_pkg::STATE_CLKS,
   parameter logic [143:0]      RST_AUTO_OUT = 144'h0
)(
   input  wire logic            CLK,
   input  wire logic            RST,
   input  wire logic [3:0]      CPU_PORT,
   input  wire logic [1:0]      CPU_REG,
   input  wire logic            CPU_WR,
   input  wire logic            CPU_RMW,
   input  wire logic [1:0]      CPU_RMW_OP,
   input  wire logic [1:0]      CPU_BE,
   input  wire logic [15:0]     CPU_WDATA,
   input  wire logic            CPU_RD,
   output logic      [15:0]     CPU_RDATA,
   output logic                 CPU_RVALID,
   input  wire logic [143:0]    PIN_I,
   output logic      [143:0]    PIN_O,
   output logic      [143:0]    PIN_OE_N,
   output logic      [17:0]     THR_CMOS,
   input  wire logic [143:0]    ALT_OUT_EN,
   input  wire logic [143:0]    ALT_OUT,
   input  wire logic [143:0]    ALT_PWM,
   input  wire logic [143:0]    ALT_DIR_HW,
   input  wire logic [143:0]    ALT_DIR_HW_OUT,
   output logic      [143:0]    ALT_IN
);
   localparam int NP = pio_pkg::NPORTS;

   logic [15:0] latch    [0:8];
   logic [15:0] dir      [0:8];
   logic [15:0] od       [0:8];
   logic [1:0]  thr      [0:8];
   logic [15:0] in_latch [0:8];
   logic [15:0] dir_eff  [0:8];
   logic [15:0] rd_value [0:8];
   logic [7:0]  div_cnt;
   logic        tick;
   logic [15:0] be_mask;
   logic [15:0] rmw_src;
   logic [15:0] rmw_res;
   logic        sel_ok;

   // byte-lane enable to bit mask
   function automatic logic [15:0] lane_mask(input logic [1:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   // rmw operation applied to an operand
   function automatic logic [15:0] rmw_apply(input logic [1:0] op, input logic [15:0] src, input logic [15:0] m);
      case (op)
         pio_pkg::RMW_SET: rmw_apply = src | m;
         pio_pkg::RMW_CLR: rmw_apply = src & ~m;
         pio_pkg::RMW_TGL: rmw_apply = src ^ m;
         default:          rmw_apply = m;
      endcase
   endfunction

   // state-time enable divider
   always_ff @(posedge CLK)
   begin
      if (RST)
         div_cnt <= 8'h00;
      else if (div_cnt >= 8'(STATE_CLKS - 1))
         div_cnt <= 8'h00;
      else
         div_cnt <= div_cnt + 8'h01;
   end
   assign tick = (div_cnt == 8'h00);

   assign sel_ok  = (CPU_PORT < 4'(NP));
   assign be_mask = lane_mask(CPU_BE); // R17

   always_comb
   begin
      rmw_src = 16'h0000;
      if (sel_ok)
         rmw_src = rd_value[CPU_PORT];
      // operand is the pin for inputs and the latch for outputs
      rmw_res = rmw_apply(CPU_RMW_OP, rmw_src, CPU_WDATA); // R3 R5
   end

   genvar p;
   generate
      for (p = 0; p < NP; p = p + 1)
      begin : g_port
         logic hit;
         assign hit = sel_ok && (CPU_PORT == 4'(p));

         // per-pin read value: latch where the software direction bit is set, input latch otherwise
         assign rd_value[p] = ((dir[p] & latch[p]) | (~dir[p] & in_latch[p])) & pio_pkg::LINE_MASK[p]; // R2 R4

         // output latch: plain writes and rmw results, written regardless of direction
         always_ff @(posedge CLK)
         begin
            if (RST)
               latch[p] <= pio_pkg::RST_LATCH; // R19
            else if (hit && CPU_REG == pio_pkg::REG_DATA && (CPU_WR || CPU_RMW))
               latch[p] <= (latch[p] & ~be_mask)
                           | ((CPU_RMW ? rmw_res : CPU_WDATA) & be_mask & pio_pkg::OUT_MASK[p]); // R2 R3 R5 R15
         end

         // direction bits
         always_ff @(posedge CLK)
         begin
            if (RST)
               dir[p] <= pio_pkg::RST_DIR; // R11
            else if (hit && CPU_REG == pio_pkg::REG_DIR && CPU_WR)
               dir[p] <= (dir[p] & ~be_mask) | (CPU_WDATA & be_mask & pio_pkg::OUT_MASK[p]); // R16 R15
         end

         // open-drain selects
         always_ff @(posedge CLK)
         begin
            if (RST)
               od[p] <= pio_pkg::RST_OD; // R19
            else if (hit && CPU_REG == pio_pkg::REG_OD && CPU_WR)
               od[p] <= (od[p] & ~be_mask) | (CPU_WDATA & be_mask & pio_pkg::OD_MASK[p]); // R6
         end

         // threshold selects, one per byte
         always_ff @(posedge CLK)
         begin
            if (RST)
               thr[p] <= pio_pkg::RST_THR; // R19
            else if (hit && CPU_REG == pio_pkg::REG_THR && CPU_WR)
               thr[p] <= (thr[p] & ~CPU_BE) | (CPU_WDATA[1:0] & CPU_BE & pio_pkg::THR_MASK[p]); // R7
         end
         // threshold only leaves the block, never touches direction or drive
         assign THR_CMOS[2*p+1:2*p] = thr[p]; // R8

         // effective direction: hardware override, reset-time auto outputs, else software
         assign dir_eff[p] = (ALT_DIR_HW[16*p+15:16*p] & ALT_DIR_HW_OUT[16*p+15:16*p]) // R13
                           | (~ALT_DIR_HW[16*p+15:16*p]
                              & (dir[p] | (RST_AUTO_OUT[16*p+15:16*p] & ALT_OUT_EN[16*p+15:16*p]))); // R14 R18

         pio_pad #(
            .LINES (pio_pkg::LINE_MASK[p]),
            .OUTS  (pio_pkg::OUT_MASK[p])
         ) u_pad (
            .clk      (CLK),
            .rst      (RST),
            .tick     (tick),
            .pin_i    (PIN_I[16*p+15:16*p]),
            .latch    (latch[p]),
            .dir_eff  (dir_eff[p]),
            .od       (od[p]),
            .alt_en   (ALT_OUT_EN[16*p+15:16*p]),
            .alt_out  (ALT_OUT[16*p+15:16*p]),
            .alt_pwm  (ALT_PWM[16*p+15:16*p]),
            .in_latch (in_latch[p]),
            .pin_o    (PIN_O[16*p+15:16*p]),
            .pin_oe_n (PIN_OE_N[16*p+15:16*p]),
            .alt_in   (ALT_IN[16*p+15:16*p])
         );
      end
   endgenerate

   // registered read port
   always_ff @(posedge CLK)
   begin
      if (RST)
         CPU_RVALID <= 1'b0;
      else
         CPU_RVALID <= CPU_RD;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         CPU_RDATA <= 16'h0000;
      else if (CPU_RD)
      begin
         if (!sel_ok)
            CPU_RDATA <= 16'h0000;
         else
         begin
            case (CPU_REG)
               pio_pkg::REG_DATA: CPU_RDATA <= rd_value[CPU_PORT]; // R2 R4
               pio_pkg::REG_DIR:  CPU_RDATA <= dir[CPU_PORT];
               pio_pkg::REG_OD:   CPU_RDATA <= od[CPU_PORT];
               default:           CPU_RDATA <= {14'h0, thr[CPU_PORT]};
            endcase
         end
      end
   end
endmodule

// ==== hdl/pio_pkg.sv ====
// constants shared by the parallel port block
package pio_pkg;
   localparam int NPORTS      = 9;
   localparam int PW          = 16;
   localparam int STATE_CLKS  = 2;
   // register selectors on the cpu access port
   localparam logic [1:0] REG_DATA = 2'h0;
   localparam logic [1:0] REG_DIR  = 2'h1;
   localparam logic [1:0] REG_OD   = 2'h2;
   localparam logic [1:0] REG_THR  = 2'h3;
   // read-modify-write operations
   localparam logic [1:0] RMW_SET = 2'h0;
   localparam logic [1:0] RMW_CLR = 2'h1;
   localparam logic [1:0] RMW_TGL = 2'h2;
   localparam logic [1:0] RMW_LD  = 2'h3;
   // reset values
   localparam logic [15:0] RST_LATCH = 16'h0000;
   localparam logic [15:0] RST_DIR   = 16'h0000;
   localparam logic [15:0] RST_OD    = 16'h0000;
   localparam logic [1:0]  RST_THR   = 2'h0;
   // implemented lines of each port
   localparam logic [15:0] LINE_MASK [0:8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hBFFF, 16'h00FF,
                                              16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF};
   // lines with output drivers
   localparam logic [15:0] OUT_MASK [0:8]  = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hBFFF, 16'h00FF,
                                              16'h0000, 16'h00FF, 16'h00FF, 16'h00FF};
   // lines with open-drain capability
   localparam logic [15:0] OD_MASK [0:8]   = '{16'h0000, 16'h0000, 16'hFFFF, 16'hBFFF, 16'h00FF,
                                              16'h0000, 16'h00FF, 16'h00FF, 16'h00FF};
   // threshold bits present, one per byte
   localparam logic [1:0]  THR_MASK [0:8]  = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h3, 2'h1, 2'h1, 2'h1};
endpackage

// ==== hdl/pio_pad.sv ====
// pin synchroniser, state-time input latch and driver logic of one port
`timescale 1ns/1ps
module pio_pad #(
   parameter logic [15:0] LINES = 16'hFFFF,
   parameter logic [15:0] OUTS  = 16'hFFFF
)(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        tick,
   input  wire logic [15:0] pin_i,
   input  wire logic [15:0] latch,
   input  wire logic [15:0] dir_eff,
   input  wire logic [15:0] od,
   input  wire logic [15:0] alt_en,
   input  wire logic [15:0] alt_out,
   input  wire logic [15:0] alt_pwm,
   output logic      [15:0] in_latch,
   output logic      [15:0] pin_o,
   output logic      [15:0] pin_oe_n,
   output logic      [15:0] alt_in
);
   logic [15:0] sync1;
   logic [15:0] sync2;
   logic [15:0] drive;
   logic [15:0] en;

   always_ff @(posedge clk)
   begin
      sync1 <= pin_i;
      sync2 <= sync1;
   end

   // sampled every state time regardless of direction
   always_ff @(posedge clk)
   begin
      if (rst)
         in_latch <= 16'h0000;
      else if (tick)
         in_latch <= sync2 & LINES; // R1
   end

   always_comb
   begin
      // pwm outputs bypass the latch, others are anded with it
      drive = (alt_en & ~alt_pwm & latch & alt_out) | (alt_en & alt_pwm & alt_out) | (~alt_en & latch); // R10
      en    = dir_eff & OUTS; // R9 R16 R15
      pin_o = drive & en & ~od; // R4
      // open drain only pulls low
      pin_oe_n = ~(en & (~od | ~drive)); // R6
      // output direction loops the latch back to the alternate input
      alt_in = (dir_eff & OUTS & latch) | (~(dir_eff & OUTS) & in_latch); // R12
   end
endmodule

// ==== tb/pio_props.sv ====
// checker for the parallel port block
`timescale 1ns/1ps
module pio_props (
   input wire logic         CLK,
   input wire logic         RST,
   input wire logic [3:0]   CPU_PORT,
   input wire logic [1:0]   CPU_REG,
   input wire logic         CPU_WR,
   input wire logic         CPU_RMW,
   input wire logic [1:0]   CPU_BE,
   input wire logic [15:0]  CPU_WDATA,
   input wire logic         CPU_RD,
   input wire logic         CPU_RVALID,
   input wire logic [143:0] PIN_O,
   input wire logic [143:0] PIN_OE_N,
   input wire logic [17:0]  THR_CMOS,
   input wire logic [143:0] ALT_OUT_EN,
   input wire logic [143:0] ALT_OUT,
   input wire logic [143:0] ALT_PWM,
   input wire logic [143:0] ALT_DIR_HW,
   input wire logic [143:0] ALT_DIR_HW_OUT,
   input wire logic [143:0] ALT_IN
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   property p_rv; CPU_RD |=> CPU_RVALID; endproperty
   a_rv: assert property (p_rv) else $error("no read answer");
   property p_rst; $past(RST) && !(|ALT_DIR_HW) && !(|ALT_OUT_EN) |-> &PIN_OE_N; endproperty
   a_rst: assert property (p_rst) else $error("pin driven after reset");
   property p_l14; PIN_OE_N[62]; endproperty
   a_l14: assert property (p_l14) else $error("absent line driven");
   property p_thra; (THR_CMOS & 18'h2A200) == 18'h0; endproperty
   a_thra: assert property (p_thra) else $error("absent threshold bit set");
   property p_thr;
      CPU_WR && CPU_REG == pio_pkg::REG_THR && CPU_PORT == 4'h2 && CPU_BE[0] |=> THR_CMOS[4] == $past(CPU_WDATA[0]);
   endproperty
   a_thr: assert property (p_thr) else $error("threshold write lost");
   property p_dir;
      CPU_WR && CPU_REG == pio_pkg::REG_DIR && CPU_PORT == 4'h0 && CPU_BE[0] && CPU_WDATA[0]
      |=> !PIN_OE_N[0] || ALT_DIR_HW[0];
   endproperty
   a_dir: assert property (p_dir) else $error("output direction not applied");
   property p_and; ALT_OUT_EN[1] && !ALT_PWM[1] && !ALT_OUT[1] |-> !PIN_O[1]; endproperty
   a_and: assert property (p_and) else $error("alternate and broken");
   property p_ain; !PIN_OE_N[2] && !ALT_OUT_EN[2] |-> ALT_IN[2] == PIN_O[2]; endproperty
   a_ain: assert property (p_ain) else $error("alternate input not latch");
   property p_hw; ALT_DIR_HW[16] && ALT_DIR_HW_OUT[16] |-> !PIN_OE_N[16]; endproperty
   a_hw: assert property (p_hw) else $error("hardware direction ignored");
   c_rmw: cover property (CPU_RMW);
   c_rv: cover property (CPU_RVALID);
   c_alt: cover property (ALT_OUT_EN[0]);
endmodule
bind pio_top pio_props i_props (.CLK(CLK), .RST(RST), .CPU_PORT(CPU_PORT), .CPU_REG(CPU_REG),
   .CPU_WR(CPU_WR), .CPU_RMW(CPU_RMW), .CPU_BE(CPU_BE), .CPU_WDATA(CPU_WDATA), .CPU_RD(CPU_RD),
   .CPU_RVALID(CPU_RVALID), .PIN_O(PIN_O), .PIN_OE_N(PIN_OE_N), .THR_CMOS(THR_CMOS),
   .ALT_OUT_EN(ALT_OUT_EN), .ALT_OUT(ALT_OUT), .ALT_PWM(ALT_PWM), .ALT_DIR_HW(ALT_DIR_HW),
   .ALT_DIR_HW_OUT(ALT_DIR_HW_OUT), .ALT_IN(ALT_IN));

// ==== tb/pio_ext.sv ====
// external devices on the pins, pull-up where nobody drives
`timescale 1ns/1ps
module pio_ext (
   input  wire logic [143:0] pin_o,
   input  wire logic [143:0] pin_oe_n,
   input  wire logic [143:0] ext_en,
   input  wire logic [143:0] ext_val,
   output logic      [143:0] pin_lvl
);
   always_comb
      for (int i = 0; i < 144; i++)
         pin_lvl[i] = !pin_oe_n[i] ? pin_o[i] : (ext_en[i] ? ext_val[i] : 1'h1);
endmodule

// ==== tb/tb_top.sv ====
// testbench for the parallel port block
`timescale 1ns/1ps
module tb_top;
   logic         CLK, RST, CPU_WR, CPU_RMW, CPU_RD, CPU_RVALID;
   logic [3:0]   CPU_PORT;
   logic [1:0]   CPU_REG, CPU_RMW_OP, CPU_BE;
   logic [15:0]  CPU_WDATA, CPU_RDATA;
   logic [143:0] PIN_I, PIN_O, PIN_OE_N, ALT_OUT_EN, ALT_OUT, ALT_PWM, ALT_DIR_HW, ALT_DIR_HW_OUT, ALT_IN;
   logic [143:0] ext_en, ext_val;
   logic [17:0]  THR_CMOS, thr_exp;
   int           n_fail, samples_checked;
   pio_top #(.RST_AUTO_OUT(144'h1 << 112)) i_dut (.CLK(CLK), .RST(RST), .CPU_PORT(CPU_PORT),
      .CPU_REG(CPU_REG), .CPU_WR(CPU_WR), .CPU_RMW(CPU_RMW), .CPU_RMW_OP(CPU_RMW_OP), .CPU_BE(CPU_BE),
      .CPU_WDATA(CPU_WDATA), .CPU_RD(CPU_RD), .CPU_RDATA(CPU_RDATA), .CPU_RVALID(CPU_RVALID),
      .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE_N(PIN_OE_N), .THR_CMOS(THR_CMOS), .ALT_OUT_EN(ALT_OUT_EN),
      .ALT_OUT(ALT_OUT), .ALT_PWM(ALT_PWM), .ALT_DIR_HW(ALT_DIR_HW), .ALT_DIR_HW_OUT(ALT_DIR_HW_OUT),
      .ALT_IN(ALT_IN));
   pio_ext i_ext (.pin_o(PIN_O), .pin_oe_n(PIN_OE_N), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(PIN_I));
   initial
   begin
      CLK = 1'h0;
      forever #2.5 CLK = ~CLK;
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // write (m=0) or read-modify-write with op r (m=1)
   task automatic acc(input logic [3:0] p, input logic [1:0] r, input logic [1:0] be, input logic [15:0] d,
                      input logic m);
      @(posedge CLK);
      CPU_PORT <= p;
      CPU_REG <= m ? pio_pkg::REG_DATA : r;
      CPU_RMW_OP <= r;
      CPU_BE <= be;
      CPU_WDATA <= d;
      CPU_WR <= !m;
      CPU_RMW <= m;
      @(posedge CLK);
      CPU_WR <= 1'h0;
      CPU_RMW <= 1'h0;
      #1;
   endtask
   task automatic rd(input logic [3:0] p, input logic [1:0] r, input logic [15:0] e, input string nm);
      @(posedge CLK);
      CPU_PORT <= p;
      CPU_REG <= r;
      CPU_RD <= 1'h1;
      @(posedge CLK);
      CPU_RD <= 1'h0;
      #1;
      chk({nm, "_v"}, {15'h0, CPU_RVALID}, 16'h1);
      chk(nm, CPU_RDATA, e);
   endtask
   task automatic tally_and_finish();
      if (n_fail == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #20000;
      n_fail++;
      tally_and_finish();
   end
   initial
   begin
      {CPU_WR, CPU_RMW, CPU_RD, CPU_PORT, CPU_REG, CPU_RMW_OP, CPU_BE, CPU_WDATA} = '0;
      {ALT_OUT_EN, ALT_OUT, ALT_PWM, ALT_DIR_HW, ALT_DIR_HW_OUT, ext_en, ext_val} = '0;
      n_fail = 0;
      samples_checked = 0;
      RST = 1'h1;
      repeat (10) @(posedge CLK);
      RST <= 1'h0;
      ext_en[47:32] <= 16'hFFFF;
      ext_val[47:32] <= 16'hA5C3;
      ext_en[95:80] <= 16'hFFFF;
      ext_val[95:80] <= 16'h5A3C;
      #1;
      chk("oe_rst", {15'h0, &PIN_OE_N}, 16'h1);
      rd(4'h2, pio_pkg::REG_DIR, 16'h0, "dir2");
      rd(4'h2, pio_pkg::REG_OD, 16'h0, "od2");
      repeat (6) @(posedge CLK);
      rd(4'h2, pio_pkg::REG_DATA, 16'hA5C3, "pin2");
      rd(4'h5, pio_pkg::REG_DATA, 16'h5A3C, "pin5");
      acc(4'h2, pio_pkg::REG_DATA, 2'h3, 16'h1234, 1'h0);
      rd(4'h2, pio_pkg::REG_DATA, 16'hA5C3, "pin2w");
      acc(4'h2, pio_pkg::RMW_SET, 2'h3, 16'h000C, 1'h1);
      @(posedge CLK);
      ext_en[47:32] <= 16'h0;
      acc(4'h2, pio_pkg::REG_DIR, 2'h3, 16'hFFFF, 1'h0);
      rd(4'h2, pio_pkg::REG_DATA, 16'hA5CF, "lat2");
      chk("pin2", PIN_O[47:32], 16'hA5CF);
      acc(4'h2, pio_pkg::RMW_TGL, 2'h3, 16'h00FF, 1'h1);
      rd(4'h2, pio_pkg::REG_DATA, 16'hA530, "tgl2");
      chk("pin2t", PIN_O[47:32], 16'hA530);
      acc(4'h2, pio_pkg::REG_OD, 2'h3, 16'hFFFF, 1'h0);
      chk("oe2_od", PIN_OE_N[47:32], 16'hA530);
      acc(4'h0, pio_pkg::REG_OD, 2'h3, 16'hFFFF, 1'h0);
      rd(4'h0, pio_pkg::REG_OD, 16'h0, "od0");
      for (int p = 0; p < 9; p++)
         acc(p[3:0], pio_pkg::REG_THR, 2'h3, 16'h0003, 1'h0);
      for (int p = 0; p < 9; p++)
         thr_exp[2*p +: 2] = pio_pkg::THR_MASK[p];
      chk("thr_lo", THR_CMOS[15:0], thr_exp[15:0]);
      chk("thr_hi", {14'h0, THR_CMOS[17:16]}, {14'h0, thr_exp[17:16]});
      rd(4'h4, pio_pkg::REG_THR, {14'h0, pio_pkg::THR_MASK[4]}, "thr4");
      chk("oe2_thr", PIN_OE_N[47:32], 16'hA530);
      acc(4'h3, pio_pkg::REG_DIR, 2'h3, 16'hFFFF, 1'h0);
      rd(4'h3, pio_pkg::REG_DIR, 16'hBFFF, "dir3");
      acc(4'h5, pio_pkg::REG_DIR, 2'h3, 16'hFFFF, 1'h0);
      rd(4'h5, pio_pkg::REG_DIR, 16'h0, "dir5");
      acc(4'h0, pio_pkg::REG_DIR, 2'h1, 16'hFFFF, 1'h0);
      rd(4'h0, pio_pkg::REG_DIR, 16'h00FF, "dir0l");
      acc(4'h0, pio_pkg::REG_DIR, 2'h2, 16'hFFFF, 1'h0);
      rd(4'h0, pio_pkg::REG_DIR, 16'hFFFF, "dir0");
      acc(4'h0, pio_pkg::REG_DATA, 2'h3, 16'hFFF6, 1'h0);
      @(posedge CLK);
      ALT_OUT_EN[3:0] <= 4'hF;
      ALT_OUT[3:0] <= 4'hD;
      ALT_PWM[3] <= 1'h1;
      ALT_OUT_EN[96] <= 1'h1;
      ALT_OUT[96] <= 1'h1;
      ALT_DIR_HW[16] <= 1'h1;
      ALT_DIR_HW_OUT[16] <= 1'h1;
      ALT_OUT_EN[112] <= 1'h1;
      #1;
      chk("alt_pin", {12'h0, PIN_O[3:0]}, 16'h000C);
      chk("alt_in", ALT_IN[15:0], 16'hFFF6);
      chk("alt_in_dir", {15'h0, PIN_OE_N[96]}, 16'h1);
      chk("auto_dir", {14'h0, PIN_OE_N[112], PIN_OE_N[16]}, 16'h0);
      tally_and_finish();
   end
endmodule
